// ===== nand_pkg.sv
package nand_pkg;

	// ************************************************************
	// Operations and states
	// ************************************************************
	typedef enum logic [2:0] {
		OP_READ = 3'b000,
		OP_PROG = 3'b001,
		OP_ERASE = 3'b010,
		OP_RESET = 3'b011,
		OP_SCAN = 3'b100
	} op_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_CHECK = 4'b0001,
		ST_PTR = 4'b0010,
		ST_CMD = 4'b0011,
		ST_ADDR = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_CMD2 = 4'b0110,
		ST_TWB = 4'b0111,
		ST_BUSY = 4'b1000,
		ST_RDATA = 4'b1001,
		ST_STCMD = 4'b1010,
		ST_STRD = 4'b1011,
		ST_HOLD = 4'b1100,
		ST_DONE = 4'b1101
	} state_t;

	// ************************************************************
	// Command bytes
	// ************************************************************
	localparam logic [7:0] CMD_READ_MAIN = 8'h00;
	localparam logic [7:0] CMD_READ_SPARE = 8'h50;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ************************************************************
	// Geometry and limits
	// ************************************************************
	localparam int MARK_COLUMN = 517;
	localparam int SPARE_BASE = 512;
	localparam logic [7:0] MARK_COL = 8'(MARK_COLUMN - SPARE_BASE);
	localparam logic [10:0] LAST_BLOCK = 11'h7FF;
	localparam logic [10:0] FIRST_BLOCK = 11'h000;
	localparam logic [1:0] NOP_MAIN = 2'h2;
	localparam logic [1:0] NOP_SPARE = 2'h3;
	localparam int STATUS_FAIL_BIT = 0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 50;
	localparam int CLK_NS = 20;
	localparam int LOAD_US = 10;
	localparam int RST_READ_US = 5;
	localparam int RST_PROG_US = 10;
	localparam int RST_ERASE_US = 500;
	localparam int RST_IDLE_US = 5;
	localparam int PROG_MAX_US = 500;
	localparam int ERASE_MAX_MS = 3;
	localparam int CEH_NS = 100;
	localparam int WB_NS = 100;
	localparam logic [17:0] LOAD_CYC = 18'(LOAD_US * CLK_MHZ);
	localparam logic [17:0] RST_IDLE_CYC = 18'(RST_IDLE_US * CLK_MHZ);
	localparam logic [17:0] RST_MAX_CYC = 18'(RST_ERASE_US * CLK_MHZ);
	localparam logic [17:0] PROG_CYC = 18'(PROG_MAX_US * CLK_MHZ);
	localparam logic [17:0] ERASE_CYC = 18'(ERASE_MAX_MS * 1000 * CLK_MHZ);
	// Strictly longer than the minimum, so one cycle on top
	localparam logic [17:0] CEH_CYC = 18'(CEH_NS / CLK_NS + 1);
	localparam logic [17:0] WB_CYC = 18'(WB_NS / CLK_NS);
	localparam logic [2:0] PH_LOW = 3'h2;
	localparam logic [2:0] PH_SAMPLE = 3'h3;
	localparam logic [2:0] PH_LAST = 3'h5;

endpackage

// ===== bbt_if.sv
interface bbt_if;
	logic wr_en;
	logic wr_bad;
	logic [10:0] waddr;
	logic [10:0] raddr;
	logic rbad;
	modport ctrl(output wr_en, output wr_bad, output waddr, output raddr,
		input rbad);
	modport store(input wr_en, input wr_bad, input waddr, input raddr,
		output rbad);
endinterface

// ===== bad_block_table.sv
// ************************************************************
// One bit per block, registered read
// ************************************************************
module bad_block_table (
	input wire logic clk,
	input wire logic clk_en,
	bbt_if.store bbt
);
	logic mem [0:2047];

	// No reset on the array: the scan writes every entry up to SCAN_LAST before use
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (bbt.wr_en) begin
				mem[bbt.waddr] <= bbt.wr_bad;
			end
			bbt.rbad <= mem[bbt.raddr];
		end
	end
endmodule

// ===== nand_host_ctrl.sv
module nand_host_ctrl #(
	parameter logic [17:0] PROG_CYC = nand_pkg::PROG_CYC,
	parameter logic [17:0] ERASE_CYC = nand_pkg::ERASE_CYC,
	parameter logic [17:0] RST_MAX_CYC = nand_pkg::RST_MAX_CYC,
	// Last block the table scan reads; lower it only to shorten a run
	parameter logic [10:0] SCAN_LAST = nand_pkg::LAST_BLOCK
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [2:0] req_op,
	input wire logic [15:0] req_row,
	input wire logic [7:0] req_col,
	input wire logic req_spare,
	input wire logic [9:0] req_len,
	input wire logic [7:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic [7:0] rd_parity,
	output logic done,
	output logic fail,
	output logic refused,
	output logic timed_out,
	output logic scanned,
	output logic nand_ce_n,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic read_strobe_n,
	output logic nand_wp_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic rb_n
);
	typedef struct packed {
		nand_pkg::state_t state;
		logic [2:0] ph;
		logic [17:0] cnt;
		logic [1:0] acnt;
		nand_pkg::op_t op;
		logic [15:0] row;
		logic [7:0] col;
		logic [9:0] len;
		logic spare;
		logic [7:0] dout;
		logic [7:0] rd_data;
		logic rd_valid;
		logic [7:0] parity;
		logic done;
		logic fail;
		logic refused;
		logic tmo;
		logic scanned;
		logic [10:0] sblk;
		logic spage;
		logic sbad;
		logic [15:0] trow;
		logic [1:0] mainc;
		logic [1:0] sparec;
		logic wr_en;
		logic wr_bad;
		logic [10:0] waddr;
	} ctrl_t;

	ctrl_t s;
	ctrl_t next_s;
	bbt_if bbt();
	logic [17:0] lim;
	logic [7:0] wbyte;
	logic is_write;
	logic is_read;
	logic blocked;
	logic same_page;

	bad_block_table table_i (
		.clk(clk),
		.clk_en(clk_en),
		.bbt(bbt)
	);

	// ************************************************************
	// Table access
	// ************************************************************
	assign bbt.raddr = (s.state == nand_pkg::ST_IDLE) ? req_row[15:5]
		: s.row[15:5];
	assign bbt.wr_en = s.wr_en;
	assign bbt.wr_bad = s.wr_bad;
	assign bbt.waddr = s.waddr;

	// ************************************************************
	// Decodes
	// ************************************************************
	// Busy limit by operation; a reset after a timeout may abort an erase
	always_comb begin
		lim = nand_pkg::LOAD_CYC;
		if (s.op == nand_pkg::OP_PROG) begin
			lim = PROG_CYC;
		end else if (s.op == nand_pkg::OP_ERASE) begin
			lim = ERASE_CYC;
		end else if (s.op == nand_pkg::OP_RESET) begin
			lim = s.tmo ? RST_MAX_CYC : nand_pkg::RST_IDLE_CYC;
		end
	end

	// Byte to put on the bus for the current write cycle
	always_comb begin
		wbyte = nand_pkg::CMD_STATUS;
		case (s.state)
			nand_pkg::ST_PTR: begin
				wbyte = s.spare ? nand_pkg::CMD_READ_SPARE : nand_pkg::CMD_READ_MAIN;
			end
			nand_pkg::ST_CMD: begin
				case (s.op)
					nand_pkg::OP_PROG: wbyte = nand_pkg::CMD_PROG;
					nand_pkg::OP_ERASE: wbyte = nand_pkg::CMD_ERASE;
					nand_pkg::OP_RESET: wbyte = nand_pkg::CMD_RESET;
					default: wbyte = s.spare ? nand_pkg::CMD_READ_SPARE
						: nand_pkg::CMD_READ_MAIN;
				endcase
			end
			nand_pkg::ST_ADDR: begin
				if (s.acnt == 2'h0) begin
					wbyte = s.col;
				end else if (s.acnt == 2'h1) begin
					wbyte = s.row[7:0];
				end else begin
					wbyte = s.row[15:8];
				end
			end
			nand_pkg::ST_WDATA: wbyte = wr_data;
			nand_pkg::ST_CMD2: begin
				wbyte = (s.op == nand_pkg::OP_PROG) ? nand_pkg::CMD_PROG_GO
					: nand_pkg::CMD_ERASE_GO;
			end
			default: wbyte = nand_pkg::CMD_STATUS;
		endcase
	end

	assign is_write = (s.state == nand_pkg::ST_PTR) ||
		(s.state == nand_pkg::ST_CMD) || (s.state == nand_pkg::ST_ADDR) ||
		(s.state == nand_pkg::ST_WDATA) || (s.state == nand_pkg::ST_CMD2) ||
		(s.state == nand_pkg::ST_STCMD);
	assign is_read = (s.state == nand_pkg::ST_RDATA) ||
		(s.state == nand_pkg::ST_STRD);
	// Known-bad blocks are off limits once the table exists
	assign blocked = s.scanned && bbt.rbad;
	assign same_page = (s.row == s.trow);

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		next_s = s;
		next_s.rd_valid = 1'b0;
		next_s.done = 1'b0;
		next_s.wr_en = 1'b0;
		if (is_write || is_read) begin
			if (s.ph != nand_pkg::PH_LAST) begin
				next_s.ph = s.ph + 3'h1;
			end
		end
		case (s.state)
			nand_pkg::ST_IDLE: begin
				// Only start while the part reports ready
				if (req_valid && rb_n) begin
					next_s.op = nand_pkg::op_t'(req_op);
					next_s.row = req_row;
					next_s.col = req_col;
					next_s.spare = req_spare;
					next_s.len = req_len;
					next_s.fail = 1'b0;
					next_s.refused = 1'b0;
					next_s.parity = 8'h00;
					next_s.state = nand_pkg::ST_CHECK;
					if (req_op == nand_pkg::OP_SCAN) begin
						// Block zero is guaranteed good, skip reading it
						next_s.wr_en = 1'b1;
						next_s.wr_bad = 1'b0;
						next_s.waddr = nand_pkg::FIRST_BLOCK;
						next_s.sblk = 11'h001;
						next_s.spage = 1'b0;
						next_s.sbad = 1'b0;
						next_s.row = 16'h0020;
						next_s.col = nand_pkg::MARK_COL;
						next_s.spare = 1'b1;
						next_s.len = 10'h001;
					end
				end
			end
			nand_pkg::ST_CHECK: begin
				next_s.ph = 3'h0;
				next_s.acnt = (s.op == nand_pkg::OP_ERASE) ? 2'h1 : 2'h0;
				next_s.state = (s.op == nand_pkg::OP_PROG) ? nand_pkg::ST_PTR
					: nand_pkg::ST_CMD;
				if (((s.op == nand_pkg::OP_PROG) || (s.op == nand_pkg::OP_ERASE))
					&& !s.scanned) begin
					next_s.refused = 1'b1;
				end
				if ((s.op == nand_pkg::OP_READ || s.op == nand_pkg::OP_PROG ||
					s.op == nand_pkg::OP_ERASE) && blocked) begin
					next_s.refused = 1'b1;
				end
				if (s.op == nand_pkg::OP_PROG && same_page &&
					(s.spare ? (s.sparec >= nand_pkg::NOP_SPARE)
					: (s.mainc >= nand_pkg::NOP_MAIN))) begin
					next_s.refused = 1'b1;
				end
				if (next_s.refused) begin
					next_s.fail = 1'b1;
					next_s.state = nand_pkg::ST_DONE;
				end else if (s.op == nand_pkg::OP_PROG) begin
					// Only the last programmed page is tracked
					if (!same_page) begin
						next_s.trow = s.row;
						next_s.mainc = 2'h0;
						next_s.sparec = 2'h0;
					end
					if (s.spare) begin
						next_s.sparec = (same_page ? s.sparec : 2'h0) + 2'h1;
					end else begin
						next_s.mainc = (same_page ? s.mainc : 2'h0) + 2'h1;
					end
				end else if (s.op == nand_pkg::OP_ERASE &&
					s.trow[15:5] == s.row[15:5]) begin
					next_s.mainc = 2'h0;
					next_s.sparec = 2'h0;
				end
			end
			nand_pkg::ST_PTR, nand_pkg::ST_CMD, nand_pkg::ST_ADDR,
			nand_pkg::ST_CMD2, nand_pkg::ST_STCMD, nand_pkg::ST_WDATA: begin
				if (s.ph == 3'h0) begin
					next_s.dout = wbyte;
					if (s.state == nand_pkg::ST_WDATA && !wr_valid) begin
						next_s.ph = 3'h0;
					end
				end else if (s.ph == nand_pkg::PH_LAST) begin
					next_s.ph = 3'h0;
					next_s.cnt = 18'h0;
					case (s.state)
						nand_pkg::ST_PTR: next_s.state = nand_pkg::ST_CMD;
						nand_pkg::ST_CMD: begin
							next_s.state = (s.op == nand_pkg::OP_RESET)
								? nand_pkg::ST_TWB : nand_pkg::ST_ADDR;
						end
						nand_pkg::ST_ADDR: begin
							next_s.acnt = s.acnt + 2'h1;
							if (s.acnt == 2'h2) begin
								if (s.op == nand_pkg::OP_PROG) begin
									next_s.state = nand_pkg::ST_WDATA;
								end else if (s.op == nand_pkg::OP_ERASE) begin
									next_s.state = nand_pkg::ST_CMD2;
								end else begin
									next_s.state = nand_pkg::ST_TWB;
								end
							end
						end
						nand_pkg::ST_WDATA: begin
							next_s.cnt = s.cnt + 18'h1;
							if (s.cnt[9:0] + 10'h1 >= s.len) begin
								next_s.state = nand_pkg::ST_CMD2;
							end
						end
						nand_pkg::ST_CMD2: next_s.state = nand_pkg::ST_TWB;
						default: next_s.state = nand_pkg::ST_STRD;
					endcase
				end
			end
			nand_pkg::ST_TWB: begin
				// Give the part time to pull busy before watching it
				next_s.cnt = s.cnt + 18'h1;
				if (s.cnt == nand_pkg::WB_CYC - 18'h1) begin
					next_s.cnt = 18'h0;
					next_s.state = nand_pkg::ST_BUSY;
				end
			end
			nand_pkg::ST_BUSY: begin
				next_s.cnt = s.cnt + 18'h1;
				next_s.ph = 3'h0;
				if (rb_n) begin
					next_s.cnt = 18'h0;
					if (s.op == nand_pkg::OP_RESET) begin
						// Through the chip enable hold, so a quick next op
						// cannot cut it short
						next_s.tmo = 1'b0;
						next_s.state = nand_pkg::ST_HOLD;
					end else if (s.op == nand_pkg::OP_PROG ||
						s.op == nand_pkg::OP_ERASE) begin
						next_s.state = nand_pkg::ST_STCMD;
					end else begin
						next_s.state = nand_pkg::ST_RDATA;
					end
				end else if (s.cnt >= lim - 18'h1) begin
					next_s.tmo = 1'b1;
					next_s.fail = 1'b1;
					next_s.cnt = 18'h0;
					next_s.state = nand_pkg::ST_HOLD;
				end
			end
			nand_pkg::ST_RDATA: begin
				if (s.ph == nand_pkg::PH_SAMPLE) begin
					next_s.rd_data = io_in;
					next_s.rd_valid = (s.op != nand_pkg::OP_SCAN);
					// Running column parity for the user's code check
					next_s.parity = s.parity ^ io_in;
					if (io_in != nand_pkg::ERASED_BYTE) begin
						next_s.sbad = 1'b1;
					end
				end else if (s.ph == nand_pkg::PH_LAST) begin
					next_s.ph = 3'h0;
					next_s.cnt = s.cnt + 18'h1;
					if (s.cnt[9:0] + 10'h1 >= s.len) begin
						next_s.cnt = 18'h0;
						next_s.state = nand_pkg::ST_HOLD;
					end
				end
			end
			nand_pkg::ST_STRD: begin
				if (s.ph == nand_pkg::PH_SAMPLE &&
					io_in[nand_pkg::STATUS_FAIL_BIT]) begin
					// Retire the block; the user moves its pages elsewhere
					next_s.fail = 1'b1;
					next_s.wr_en = 1'b1;
					next_s.wr_bad = 1'b1;
					next_s.waddr = s.row[15:5];
				end else if (s.ph == nand_pkg::PH_LAST) begin
					next_s.cnt = 18'h0;
					next_s.state = nand_pkg::ST_HOLD;
				end
			end
			nand_pkg::ST_HOLD: begin
				// Chip enable off long enough to end any sequential read
				next_s.cnt = s.cnt + 18'h1;
				if (s.cnt == nand_pkg::CEH_CYC - 18'h1) begin
					next_s.cnt = 18'h0;
					next_s.state = nand_pkg::ST_DONE;
					if (s.op == nand_pkg::OP_SCAN && !s.tmo) begin
						next_s.state = nand_pkg::ST_CMD;
						// Each page read restarts at the column byte
						next_s.acnt = 2'h0;
						if (!s.spage) begin
							next_s.spage = 1'b1;
							next_s.row = {s.sblk, 5'h01};
						end else begin
							next_s.wr_en = 1'b1;
							next_s.wr_bad = s.sbad;
							next_s.waddr = s.sblk;
							next_s.sbad = 1'b0;
							next_s.spage = 1'b0;
							next_s.sblk = s.sblk + 11'h001;
							next_s.row = {s.sblk + 11'h001, 5'h00};
							if (s.sblk == SCAN_LAST) begin
								next_s.scanned = 1'b1;
								next_s.state = nand_pkg::ST_DONE;
							end
						end
					end
				end
			end
			nand_pkg::ST_DONE: begin
				next_s.done = 1'b1;
				next_s.state = nand_pkg::ST_IDLE;
			end
			default: next_s.state = nand_pkg::ST_IDLE;
		endcase
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// ************************************************************
	// Pins and user outputs
	// ************************************************************
	// Strobes decode from flops only, so each changes once per edge
	assign nand_ce_n = !(is_write || is_read ||
		s.state == nand_pkg::ST_TWB || s.state == nand_pkg::ST_BUSY);
	assign nand_cle = (s.state == nand_pkg::ST_PTR) ||
		(s.state == nand_pkg::ST_CMD) || (s.state == nand_pkg::ST_CMD2) ||
		(s.state == nand_pkg::ST_STCMD);
	assign nand_ale = (s.state == nand_pkg::ST_ADDR);
	assign nand_we_n = !(is_write && (s.ph == nand_pkg::PH_LOW ||
		s.ph == nand_pkg::PH_LOW + 3'h1));
	assign read_strobe_n = !(is_read && s.ph != 3'h0 &&
		s.ph <= nand_pkg::PH_SAMPLE);
	assign nand_wp_n = 1'b1;
	assign io_oe = is_write && s.ph != 3'h0;
	assign io_out = s.dout;
	assign wr_ready = (s.state == nand_pkg::ST_WDATA) && (s.ph == 3'h0);
	assign req_ready = (s.state == nand_pkg::ST_IDLE) && rb_n;
	assign rd_data = s.rd_data;
	assign rd_valid = s.rd_valid;
	assign rd_parity = s.parity;
	assign done = s.done;
	assign fail = s.fail;
	assign refused = s.refused;
	assign timed_out = s.tmo;
	assign scanned = s.scanned;
endmodule

// ===== nand_host_ctrl_assertions.sv
// ********
// Host pin protocol checks
// ********
module nand_host_ctrl_checker #(
	parameter logic [17:0] PROG_CYC = nand_pkg::PROG_CYC,
	parameter logic [17:0] ERASE_CYC = nand_pkg::ERASE_CYC,
	parameter logic [17:0] RST_MAX_CYC = nand_pkg::RST_MAX_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic done,
	input wire logic fail,
	input wire logic refused,
	input wire logic scanned,
	input wire logic nand_ce_n,
	input wire logic nand_cle,
	input wire logic nand_ale,
	input wire logic nand_we_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic rb_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Strobe shapes: writes low two clocks, reads low three
	sequence we_pulse;
		!nand_we_n ##1 !nand_we_n ##1 nand_we_n;
	endsequence
	sequence rs_pulse;
		!read_strobe_n [*3] ##1 read_strobe_n;
	endsequence
	sequence strobe_start;
		$fell(nand_we_n) || $fell(read_strobe_n);
	endsequence

	a_we_width: assert property ($fell(nand_we_n) |-> we_pulse)
		else $error("write strobe width wrong");
	a_rd_width: assert property ($fell(read_strobe_n) |-> rs_pulse)
		else $error("read strobe width wrong");
	a_cycle_ready: assert property (strobe_start |-> rb_n)
		else $error("bus cycle started while device busy");
	a_ce_hold: assert property ($rose(nand_ce_n) |-> nand_ce_n [*6])
		else $error("chip enable high for too short a time");
	a_refused_quiet: assert property (refused |-> nand_ce_n && fail)
		else $error("refused operation touched the pins");
	a_scan_first: assert property ($fell(nand_we_n) &&
		nand_cle &&
		(io_out == nand_pkg::CMD_ERASE || io_out == nand_pkg::CMD_PROG)
		|-> scanned)
		else $error("program or erase before table built");
	a_bus_turn: assert property (!read_strobe_n |-> !io_oe)
		else $error("host drives data while device drives it");
	a_pin_excl: assert property ((nand_cle || nand_ale) |->
		!nand_ce_n && !(nand_cle && nand_ale))
		else $error("latch enables outside a selected cycle");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule

bind nand_host_ctrl nand_host_ctrl_checker #(.PROG_CYC(PROG_CYC),
	.ERASE_CYC(ERASE_CYC), .RST_MAX_CYC(RST_MAX_CYC)) u_chk (
	.clk(clk), .rst_n(rst_n), .done(done), .fail(fail), .refused(refused),
	.scanned(scanned), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle),
	.nand_ale(nand_ale), .nand_we_n(nand_we_n),
	.read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe),
	.rb_n(rb_n));

// ===== nand_flash_model.sv
// ********
// Behavioural flash device
// ********
module nand_flash_model #(
	parameter int LOAD_NS = 200,
	parameter int PROG_NS = 2000,
	parameter int ERASE_NS = 4000,
	parameter int RST_NS = 1000
) (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] din,
	input wire logic fail_next,
	output logic [7:0] dq,
	output logic rb_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	logic [7:0] pend [int];
	logic [7:0] cmd = 8'h00;
	logic [7:0] last = 8'h00;
	logic [7:0] cur = 8'hFF;
	logic [15:0] row = 16'h0000;
	logic fail = 1'h0;
	logic loading = 1'h0;
	int col = 0;
	int base = 0;
	int na = 0;
	int stamp = 0;

	// Released data lines show the inverse of the last byte, never a hold
	assign dq = (!ce_n && !read_strobe_n) ? cur : ~last;

	function automatic logic [7:0] peek(input int k);
		return mem.exists(k) ? mem[k] : 8'hFF;
	endfunction

	// Busy window; a newer window cancels an older one
	task automatic go_busy(input int ns);
		int my;
		stamp++;
		my = stamp;
		rb_n = 1'h0;
		fork
			begin
				#(ns * 1ns);
				if (my == stamp) begin
					rb_n = 1'h1;
					loading = 1'h0;
				end
			end
		join_none
	endtask

	// Factory marks; block zero is left clean on purpose
	initial begin
		rb_n = 1'h1;
		mem[161 * 528 + 517] = 8'h00;
		mem[288 * 528 + 517] = 8'h3C;
	end

	// Commands, addresses and data latch on the rising write strobe
	always @(posedge we_n) if (!ce_n) begin
		if (cle) begin
			cmd = din;
			na = 0;
			case (din)
				8'h00: base = 0;
				8'h50: base = 512;
				8'h80: pend.delete();
				8'h10: begin
					// A failed page leaves every other page untouched
					if (!fail_next) begin
						foreach (pend[k]) mem[k] = peek(k) & pend[k];
					end
					fail = fail_next;
					go_busy(PROG_NS);
				end
				8'hD0: begin
					for (int k = 0; k < 32 * 528; k++)
						mem.delete(int'(row[15:5]) * 32 * 528 + k);
					fail = 1'h0;
					go_busy(ERASE_NS);
				end
				8'hFF: begin
					loading = 1'h0;
					go_busy(RST_NS);
				end
				default: ;
			endcase
		end else if (ale) begin
			case ((cmd == 8'h60) ? na + 1 : na)
				0: col = base + int'(din);
				1: row[7:0] = din;
				default: begin
					row[15:8] = din;
					if (cmd == 8'h00 || cmd == 8'h50) begin
						loading = 1'h1;
						go_busy(LOAD_NS);
					end
				end
			endcase
			na++;
		end else if (cmd == 8'h80) begin
			pend[int'(row) * 528 + col] = din;
			col++;
		end
	end

	// Data leaves on the falling read strobe and steps on the rising one
	always @(negedge read_strobe_n) if (!ce_n)
		cur = (cmd == 8'h70) ? {1'h1, rb_n, 5'h00, fail}
			: peek(int'(row) * 528 + col);
	always @(posedge read_strobe_n) if (!ce_n) begin
		last = cur;
		col++;
	end

	// Chip enable dropped during a page load frees the busy line early
	always @(posedge ce_n) if (loading) go_busy(40);
endmodule

// ===== test_nand_host_ctrl.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

// ********
// Host controller bench
// ********
module test_nand_host_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [2:0] op;
		logic [15:0] row;
		logic [7:0] col;
		logic sp;
		logic [9:0] len;
		logic rf;
		logic pat;
	} case_t;
	localparam int LIM = 20000;
	logic clk, rst_n, clk_en, req_valid, req_spare, wr_valid, fail_next;
	logic req_ready, wr_ready, rd_valid, done, fail, refused, timed_out;
	logic scanned, nand_ce_n, nand_cle, nand_ale, nand_we_n, read_strobe_n;
	logic nand_wp_n, io_oe, rb_n, saw_busy;
	logic [2:0] req_op;
	logic [15:0] req_row;
	logic [9:0] req_len;
	logic [7:0] req_col, wr_data, rd_data, rd_parity, io_out, dq, par;
	logic [7:0] rd_q [$];
	wire logic [7:0] io_bus = io_oe ? io_out : dq;
	int error_cnt = 0;
	int compares = 0;
	case_t c;
	// Op, page row, column, spare, length, refused, programmed pattern
	case_t cases [18] = '{
		'{3'h1, 16'h0062, 8'h04, 1'h0, 10'h004, 1'h1, 1'h0},
		'{3'h4, 16'h0000, 8'h00, 1'h0, 10'h001, 1'h0, 1'h0},
		'{3'h1, 16'h0062, 8'h04, 1'h0, 10'h004, 1'h0, 1'h0},
		'{3'h0, 16'h0062, 8'h04, 1'h0, 10'h004, 1'h0, 1'h1},
		'{3'h1, 16'h0062, 8'h04, 1'h0, 10'h004, 1'h0, 1'h0},
		'{3'h1, 16'h0062, 8'h04, 1'h0, 10'h004, 1'h1, 1'h0},
		'{3'h1, 16'h0062, 8'h00, 1'h1, 10'h002, 1'h0, 1'h0},
		'{3'h1, 16'h0062, 8'h00, 1'h1, 10'h002, 1'h0, 1'h0},
		'{3'h1, 16'h0062, 8'h00, 1'h1, 10'h002, 1'h0, 1'h0},
		'{3'h1, 16'h0062, 8'h00, 1'h1, 10'h002, 1'h1, 1'h0},
		'{3'h0, 16'h0062, 8'h00, 1'h1, 10'h002, 1'h0, 1'h1},
		'{3'h0, 16'h00A1, 8'h00, 1'h0, 10'h001, 1'h1, 1'h0},
		'{3'h2, 16'h0120, 8'h00, 1'h0, 10'h001, 1'h1, 1'h0},
		'{3'h0, 16'h0000, 8'h00, 1'h0, 10'h003, 1'h0, 1'h0},
		'{3'h2, 16'h0060, 8'h00, 1'h0, 10'h001, 1'h0, 1'h0},
		'{3'h0, 16'h0062, 8'h04, 1'h0, 10'h004, 1'h0, 1'h0},
		'{3'h1, 16'h0062, 8'h04, 1'h0, 10'h004, 1'h0, 1'h0},
		'{3'h3, 16'h0000, 8'h00, 1'h0, 10'h001, 1'h0, 1'h0}};

	// Short scan keeps the run small; both marked blocks lie below 16
	nand_host_ctrl #(.PROG_CYC(18'h00258), .ERASE_CYC(18'h00258),
		.RST_MAX_CYC(18'h00258), .SCAN_LAST(11'h00F)) dut (.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_row(req_row), .req_col(req_col),
		.req_spare(req_spare), .req_len(req_len), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .rd_parity(rd_parity), .done(done),
		.fail(fail), .refused(refused), .timed_out(timed_out),
		.scanned(scanned), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle),
		.nand_ale(nand_ale), .nand_we_n(nand_we_n),
		.read_strobe_n(read_strobe_n), .nand_wp_n(nand_wp_n),
		.io_out(io_out), .io_oe(io_oe), .io_in(io_bus), .rb_n(rb_n));
	nand_flash_model dev (.ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale),
		.we_n(nand_we_n), .read_strobe_n(read_strobe_n), .din(io_bus),
		.fail_next(fail_next), .dq(dq), .rb_n(rb_n));

	task automatic conclude();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One whole operation; inputs move on falling edges only
	task automatic run_op(input case_t t);
		int n;
		logic take;
		take = 1'h0;
		saw_busy = 1'h0;
		rd_q.delete();
		@(negedge clk);
		{req_op, req_row, req_col, req_spare, req_len} =
			{t.op, t.row, t.col, t.sp, t.len};
		req_valid = 1'h1;
		wr_valid = 1'h1;
		wr_data = 8'hA0;
		for (n = 0; n < 1000 && req_ready !== 1'h1; n++) @(negedge clk);
		if (n == 1000) begin
			error_cnt++;
			conclude();
		end
		@(negedge clk);
		req_valid = 1'h0;
		for (n = 0; n < LIM; n++) begin
			@(negedge clk);
			if (take) wr_data = wr_data + 8'h01;
			take = wr_ready;
			if (rb_n === 1'h0) saw_busy = 1'h1;
			if (rd_valid === 1'h1) rd_q.push_back(rd_data);
			if (done === 1'h1) break;
		end
		if (n == LIM) begin
			error_cnt++;
			conclude();
		end
	endtask

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// Refused program first, then table pass, failure, mid-run reset and wrap-up
	initial begin
		{rst_n, req_valid, req_spare, wr_valid, fail_next} = 5'h00;
		{req_op, req_row, req_col, req_len, wr_data} = 45'h0;
		clk_en = 1'h1;
		repeat (16) @(negedge clk);
		`CHK({nand_ce_n, nand_wp_n, io_oe, done, scanned}, 5'h18)
		rst_n = 1'h1;
		foreach (cases[i]) begin
			run_op(cases[i]);
			`CHK(refused, cases[i].rf)
			`CHK(saw_busy, ~cases[i].rf)
			`CHK(timed_out, 1'h0)
			if (cases[i].op == 3'h4) `CHK(scanned, 1'h1)
			if (cases[i].op == 3'h0 && !cases[i].rf) begin
				par = 8'h00;
				`CHK(rd_q.size(), int'(cases[i].len))
				foreach (rd_q[j]) begin
					c.col = cases[i].pat ? 8'hA0 + 8'(j) : 8'hFF;
					par = par ^ c.col;
					`CHK(rd_q[j], c.col)
				end
				`CHK(rd_parity, par)
			end
		end
		c = cases[2];
		c.row = 16'h00E0;
		fail_next = 1'h1;
		run_op(c);
		`CHK({fail, refused}, 2'h2)
		fail_next = 1'h0;
		c.op = 3'h0;
		run_op(c);
		`CHK(refused, 1'h1)
		rst_n = 1'h0;
		repeat (2) @(negedge clk);
		rst_n = 1'h1;
		// Frozen clock enable must hold off even a quickly refused request
		clk_en = 1'h0;
		{req_op, req_valid} = 4'h3;
		repeat (4) @(negedge clk);
		`CHK({done, refused, nand_ce_n}, 3'h1)
		{clk_en, req_valid} = 2'h2;
		run_op(cases[0]);
		`CHK({refused, scanned}, 2'h2)
		conclude();
	end
endmodule
